// file: include/smbus_control_map.svh
// Offsets, field positions and reset values of the control register.
// Included by the design files; holds definitions only.
`ifndef SMBUS_CONTROL_MAP_SVH
`define SMBUS_CONTROL_MAP_SVH

`define CTRL_OFFSET     8'h90
`define CTRL_RESET      8'h00
`define CTRL_EN_BIT     7
`define CTRL_IEN_BIT    6
`define CTRL_MASTER_SELECT_BIT   5
`define CTRL_MTX_BIT    4
`define CTRL_ACK_DRIVE_VALUE_BIT   3
`define CTRL_REPEAT_START_REQUEST_BIT   2
`define UNMAPPED_DATA   8'h00
`define REQ_START       0
`define REQ_STOP        1
`define REQ_RSTART      2

`endif

// file: include/smbus_control_pkg.sv
// Types shared by the control register and its link-side sequencer.
// Assumes smbus_control_map.svh on the include path.
package smbus_control_pkg;

    typedef enum logic [2:0] {
        BUS_IDLE  = 3'b001,
        BUS_ADDR  = 3'b010,
        BUS_XFER  = 3'b100
    } bus_state_t;

    typedef enum logic [6:0] {
        LNK_IDLE  = 7'h01,
        LNK_S1    = 7'h02,
        LNK_S2    = 7'h04,
        LNK_P1    = 7'h08,
        LNK_P2    = 7'h10,
        LNK_R1    = 7'h20,
        LNK_R2    = 7'h40
    } link_state_t;

    typedef struct packed {
        bus_state_t bst;
        logic       hit;
        logic       rd;
        logic [7:0] dout;
        logic       doe;
        logic       rdy_n;
        logic       en;
        logic       ien;
        logic       master_select;
        logic       direction_select;
        logic       ack_drive_value;
        logic [2:0] tgl;
        logic       arb;
        logic       irq_n;
    } core_st_t;

    typedef struct packed {
        logic        rs1;
        logic        rs2;
        logic [1:0]  lv1;
        logic [1:0]  lv2;
        logic [2:0]  t1;
        logic [2:0]  t2;
        logic [2:0]  tref;
        link_state_t lst;
        logic        sda_o;
        logic        sda_oe;
        logic        scl_o;
        logic        scl_oe;
    } link_st_t;

endpackage

// file: include/ctrl_link_if.sv
// Control levels and request toggles from the core domain to the link domain.
// Driver side runs on the core clock; receiver side synchronises everything.
interface ctrl_link_if;
    logic       run;
    logic       direction_select;
    logic       ack_drive_value;
    logic [2:0] req_tgl;

    modport core (output run, output direction_select, output ack_drive_value, output req_tgl);
    modport link (input run, input direction_select, input ack_drive_value, input req_tgl);
endinterface

// file: hw/smbus_link_seq.sv
// Link-side sequencer: START, STOP, repeated START and acknowledge drive.
// Runs on the link clock; all inputs from the core domain pass two flops.
`include "smbus_control_map.svh"

module smbus_link_seq
    import smbus_control_pkg::*;
(
    input  wire logic  link_clk_i,
    input  wire logic  ack_slot_i,
    ctrl_link_if.link  lk,
    output logic       sda_o,
    output logic       sda_oe_o,
    output logic       scl_o,
    output logic       scl_oe_o
);
    import smbus_control_pkg::*;

    link_st_t st_r;
    link_st_t st_nxt;
    logic [2:0] edge_w;

    assign edge_w = st_r.t2 ^ st_r.tref;

    // ========================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.rs1 = lk.run;
        st_nxt.rs2 = st_r.rs1;
        st_nxt.lv1 = {lk.direction_select, lk.ack_drive_value};
        st_nxt.lv2 = st_r.lv1;
        st_nxt.t1 = lk.req_tgl;
        st_nxt.t2 = st_r.t1;
        case (st_r.lst)
            LNK_IDLE: begin
                st_nxt.sda_oe = ack_slot_i && !st_r.lv2[1] && !st_r.lv2[0]; // R09
                st_nxt.scl_oe = 1'b0;
                if (edge_w[`REQ_STOP]) begin
                    st_nxt.tref[`REQ_STOP] = st_r.t2[`REQ_STOP];
                    st_nxt.lst = LNK_P1; // R06
                end else if (edge_w[`REQ_RSTART]) begin
                    st_nxt.tref[`REQ_RSTART] = st_r.t2[`REQ_RSTART];
                    st_nxt.lst = LNK_R1; // R11
                end else if (edge_w[`REQ_START]) begin
                    st_nxt.tref[`REQ_START] = st_r.t2[`REQ_START];
                    st_nxt.lst = LNK_S1; // R05
                end
            end
            LNK_S1: begin
                st_nxt.sda_oe = 1'b1;
                st_nxt.scl_oe = 1'b0;
                st_nxt.lst = LNK_S2;
            end
            LNK_S2: begin
                st_nxt.scl_oe = 1'b1;
                st_nxt.lst = LNK_IDLE;
            end
            LNK_P1: begin
                // Clock and data low together, so no START is seen
                st_nxt.sda_oe = 1'b1;
                st_nxt.scl_oe = 1'b1;
                st_nxt.lst = LNK_P2;
            end
            LNK_P2: begin
                // Clock released; idle then releases data high
                st_nxt.sda_oe = 1'b1;
                st_nxt.scl_oe = 1'b0;
                st_nxt.lst = LNK_IDLE;
            end
            LNK_R1: begin
                st_nxt.sda_oe = 1'b0;
                st_nxt.scl_oe = 1'b1;
                st_nxt.lst = LNK_R2;
            end
            LNK_R2: begin
                st_nxt.scl_oe = 1'b0;
                st_nxt.lst = LNK_S1;
            end
            default: st_nxt.lst = LNK_IDLE;
        endcase
        st_nxt.sda_o = 1'b0;
        st_nxt.scl_o = 1'b0;
        // Held in reset while disabled; request history tracks meanwhile
        if (!st_r.rs2) begin
            st_nxt.lst = LNK_IDLE; // R02
            st_nxt.sda_oe = 1'b0;
            st_nxt.scl_oe = 1'b0;
            st_nxt.tref = st_r.t2;
        end
    end

    always_ff @(posedge link_clk_i) begin
        st_r <= st_nxt;
    end

    assign sda_o    = st_r.sda_o;
    assign sda_oe_o = st_r.sda_oe;
    assign scl_o    = st_r.scl_o;
    assign scl_oe_o = st_r.scl_oe;

    // ========================================
    // Checks
    default clocking cb @(posedge link_clk_i); endclocking
    default disable iff (!st_r.rs2);

    sequence seq_start;
        st_r.lst == LNK_S1 ##1 st_r.lst == LNK_S2;
    endsequence

    AST_LINK_ACK: assert property ( // R09
        st_r.lst == LNK_IDLE && edge_w == 3'b000 && ack_slot_i && !st_r.lv2[1]
        |=> sda_oe_o == !$past(st_r.lv2[0]) && !scl_oe_o)
        else $error("ack value not driven on data line");
    AST_LINK_START: assert property ( // R05
        seq_start |=> sda_oe_o && scl_oe_o && st_r.lst == LNK_IDLE)
        else $error("start condition malformed");
endmodule

// file: hw/smbus_control.sv
// Control register of the two-wire controller with its host bus slave.
// Host bus is synchronous to CORE_CLK_I; the two-wire side runs on LINK_CLK_I.
//
// Contract
// (R01) Enable bit 7 gates all other bits
// (R02) Enable clear holds link logic reset
// (R03) Interrupt enable bit 6 passes pending flag
// (R04) Interrupt enable clear masks, pending untouched
// (R05) Master select rise issues START, master
// (R06) Master select clear issues STOP, slave
// (R07) Arbitration loss clears master, no STOP
// (R08) Direction bit 4: one transmits
// (R09) Ack value bit 3 driven in ack
// (R10) Software sets no-ack before last byte
// (R11) Repeat start bit 2 issues repeated START
// (R12) Repeat start bit always reads zero
// (R13) Misplaced repeated START counts as lost
// (R14) Lost arbitration: flag, slave, clear master
// (R15) START while busy sets lost flag
// (R16) Interrupt output active low, pending and enabled
// (R17) Reserved low bits read zero
// (R18) All control bits zero after reset
`include "smbus_control_map.svh"

module smbus_control
    import smbus_control_pkg::*;
(
    input  wire logic       CORE_CLK_I,
    input  wire logic       RESETN_I,
    input  wire logic       LINK_CLK_I,
    input  wire logic [7:0] ADDR_I,
    input  wire logic [7:0] DATA_I,
    output logic [7:0]      DATA_O,
    output logic            DATA_OE_O,
    input  wire logic       BS_N_I,
    input  wire logic       CS_N_I,
    input  wire logic       RD_WRN_I,
    input  wire logic       RD_N_I,
    input  wire logic       WE_N_I,
    output logic            RDY_N_O,
    input  wire logic       PENDING_I,
    input  wire logic       ARB_LOST_I,
    input  wire logic       BUS_BUSY_I,
    input  wire logic       ACK_SLOT_I,
    output logic            IRQ_N_O,
    output logic            ARB_LOST_O,
    output logic            ENABLE_O,
    output logic            MASTER_O,
    output logic            TRANSMIT_O,
    output logic            SDA_O,
    output logic            SDA_OE_O,
    output logic            SCL_O,
    output logic            SCL_OE_O
);
    import smbus_control_pkg::*;

    core_st_t st_r;
    core_st_t st_nxt;
    logic     wr_ev;
    logic     rd_ev;

    ctrl_link_if lnk ();

    // ========================================
    // Register read image
    function automatic logic [7:0] ctrl_image(input core_st_t s);
        logic [7:0] v;
        v = `CTRL_RESET;
        v[`CTRL_EN_BIT]   = s.en;
        v[`CTRL_IEN_BIT]  = s.ien;
        v[`CTRL_MASTER_SELECT_BIT] = s.master_select;
        v[`CTRL_MTX_BIT]  = s.direction_select;
        v[`CTRL_ACK_DRIVE_VALUE_BIT] = s.ack_drive_value;
        return v;
    endfunction

    // ========================================
    // Write qualifier: stored and written enable both set
    function automatic logic fields_open(input core_st_t s, input logic [7:0] d);
        return s.en && d[`CTRL_EN_BIT];
    endfunction

    // ========================================
    // Bus strobes
    assign wr_ev = (st_r.bst == BUS_ADDR) && !WE_N_I && !st_r.rd && st_r.hit;
    assign rd_ev = (st_r.bst == BUS_ADDR) && !RD_N_I && st_r.rd;

    // ========================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.arb = 1'b0;

        // Host bus cycle
        case (st_r.bst)
            BUS_IDLE: begin
                if (!BS_N_I && !CS_N_I) begin
                    st_nxt.bst = BUS_ADDR;
                    st_nxt.hit = (ADDR_I == `CTRL_OFFSET);
                    st_nxt.rd = RD_WRN_I;
                end
            end
            BUS_ADDR: begin
                if (!WE_N_I || !RD_N_I) begin
                    st_nxt.bst = BUS_XFER;
                    st_nxt.rdy_n = 1'b0;
                    st_nxt.doe = st_r.rd;
                    // Bits 2..0 never stored, so they read zero
                    st_nxt.dout = st_r.hit ? ctrl_image(st_r) : `UNMAPPED_DATA; // R12 R17
                end
            end
            BUS_XFER: begin
                if (BS_N_I && CS_N_I) begin
                    st_nxt.bst = BUS_IDLE;
                    st_nxt.rdy_n = 1'b1;
                    st_nxt.doe = 1'b0;
                end
            end
            default: begin
                st_nxt.bst = BUS_IDLE;
                st_nxt.rdy_n = 1'b1;
                st_nxt.doe = 1'b0;
            end
        endcase

        // Register write
        if (wr_ev) begin
            st_nxt.en = DATA_I[`CTRL_EN_BIT];
            if (fields_open(st_r, DATA_I)) begin // R01
                st_nxt.ien = DATA_I[`CTRL_IEN_BIT]; // R04
                st_nxt.direction_select = DATA_I[`CTRL_MTX_BIT]; // R08
                st_nxt.ack_drive_value = DATA_I[`CTRL_ACK_DRIVE_VALUE_BIT]; // R09
                if (DATA_I[`CTRL_MASTER_SELECT_BIT] && !st_r.master_select) begin
                    if (BUS_BUSY_I) begin
                        st_nxt.arb = 1'b1; // R15
                    end else begin
                        st_nxt.master_select = 1'b1; // R05
                        st_nxt.tgl[`REQ_START] = !st_r.tgl[`REQ_START];
                    end
                end else if (!DATA_I[`CTRL_MASTER_SELECT_BIT] && st_r.master_select) begin
                    st_nxt.master_select = 1'b0; // R06
                    st_nxt.tgl[`REQ_STOP] = !st_r.tgl[`REQ_STOP];
                end
                if (DATA_I[`CTRL_REPEAT_START_REQUEST_BIT]) begin
                    if (st_r.master_select) begin
                        st_nxt.tgl[`REQ_RSTART] = !st_r.tgl[`REQ_RSTART]; // R11
                    end else if (BUS_BUSY_I) begin
                        st_nxt.arb = 1'b1; // R13
                    end
                end
            end
        end

        // Lost arbitration overrides the master select and START/STOP toggles of a write in the same cycle
        if (ARB_LOST_I) begin
            st_nxt.arb = 1'b1; // R14
            if (st_r.master_select || st_nxt.master_select) begin
                st_nxt.master_select = 1'b0;
                st_nxt.tgl[`REQ_STOP] = st_r.tgl[`REQ_STOP]; // R07
                st_nxt.tgl[`REQ_START] = st_r.tgl[`REQ_START];
            end
        end

        // Disabled controller keeps every other bit cleared
        if (!st_nxt.en) begin
            st_nxt.ien = 1'b0; // R01
            st_nxt.master_select = 1'b0;
            st_nxt.direction_select = 1'b0;
            st_nxt.ack_drive_value = 1'b0;
        end

        st_nxt.irq_n = !(PENDING_I && st_r.ien); // R03 R16

        if (!RESETN_I) begin
            st_nxt.bst = BUS_IDLE; // R18
            st_nxt.hit = 1'b0;
            st_nxt.rd = 1'b0;
            st_nxt.dout = `CTRL_RESET;
            st_nxt.doe = 1'b0;
            st_nxt.rdy_n = 1'b1;
            st_nxt.en = 1'b0;
            st_nxt.ien = 1'b0;
            st_nxt.master_select = 1'b0;
            st_nxt.direction_select = 1'b0;
            st_nxt.ack_drive_value = 1'b0;
            st_nxt.tgl = 3'h0;
            st_nxt.arb = 1'b0;
            st_nxt.irq_n = 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        st_r <= st_nxt;
    end

    // ========================================
    // Crossing to the link domain
    assign lnk.run = st_r.en; // R02
    assign lnk.direction_select = st_r.direction_select;
    assign lnk.ack_drive_value = st_r.ack_drive_value;
    assign lnk.req_tgl = st_r.tgl;

    smbus_link_seq u_link (
        .link_clk_i (LINK_CLK_I),
        .ack_slot_i (ACK_SLOT_I),
        .lk         (lnk),
        .sda_o      (SDA_O),
        .sda_oe_o   (SDA_OE_O),
        .scl_o      (SCL_O),
        .scl_oe_o   (SCL_OE_O)
    );

    // ========================================
    // Outputs
    assign DATA_O     = st_r.dout;
    assign DATA_OE_O  = st_r.doe;
    assign RDY_N_O    = st_r.rdy_n;
    assign IRQ_N_O    = st_r.irq_n;
    assign ARB_LOST_O = st_r.arb;
    assign ENABLE_O   = st_r.en;
    assign MASTER_O   = st_r.master_select;
    assign TRANSMIT_O = st_r.direction_select;

    // ========================================
    // Checks
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESETN_I);

    sequence seq_wr_start;
        wr_ev && st_r.en && DATA_I[`CTRL_EN_BIT] && DATA_I[`CTRL_MASTER_SELECT_BIT]
            && !st_r.master_select && !ARB_LOST_I;
    endsequence

    sequence seq_wr_stop;
        wr_ev && st_r.en && DATA_I[`CTRL_EN_BIT] && !DATA_I[`CTRL_MASTER_SELECT_BIT]
            && st_r.master_select && !ARB_LOST_I;
    endsequence

    sequence seq_wr_fields;
        wr_ev && fields_open(st_r, DATA_I);
    endsequence

    sequence seq_wr_rstart;
        wr_ev && fields_open(st_r, DATA_I) && DATA_I[`CTRL_REPEAT_START_REQUEST_BIT] && st_r.master_select;
    endsequence

    sequence seq_rd_unmapped;
        rd_ev && !st_r.hit;
    endsequence

    AST_EN_GATES: assert property ( // R01
        !ENABLE_O |-> !st_r.ien && !MASTER_O && !TRANSMIT_O && !st_r.ack_drive_value)
        else $error("control bits set while disabled");
    AST_IRQ_RAISE: assert property ( // R03
        PENDING_I && st_r.ien ##1 PENDING_I && st_r.ien |=> !IRQ_N_O)
        else $error("interrupt not raised");
    AST_IRQ_MASK: assert property ( // R04
        !st_r.ien |=> IRQ_N_O)
        else $error("interrupt not masked");
    AST_START: assert property ( // R05
        (seq_wr_start and !BUS_BUSY_I)
        |=> MASTER_O && $changed(st_r.tgl[`REQ_START]) && $stable(st_r.tgl[`REQ_STOP]))
        else $error("start not requested");
    AST_STOP: assert property ( // R06
        seq_wr_stop |=> !MASTER_O && $changed(st_r.tgl[`REQ_STOP]))
        else $error("stop not requested");
    AST_ARB_NO_STOP: assert property ( // R07
        ARB_LOST_I |=> !MASTER_O && ARB_LOST_O && $stable(st_r.tgl[`REQ_STOP]))
        else $error("stop issued after lost arbitration");
    AST_BUSY_START: assert property ( // R15
        (seq_wr_start and BUS_BUSY_I) |=> ARB_LOST_O && !MASTER_O)
        else $error("busy start not flagged");
    AST_REPEAT_START_REQUEST_SLAVE: assert property ( // R13
        wr_ev && st_r.en && DATA_I[`CTRL_EN_BIT] && DATA_I[`CTRL_REPEAT_START_REQUEST_BIT]
            && !st_r.master_select && BUS_BUSY_I
        |=> ARB_LOST_O && $stable(st_r.tgl[`REQ_RSTART]))
        else $error("misplaced repeated start not flagged");
    AST_REPEAT_START_REQUEST_READ: assert property ( // R12
        rd_ev && st_r.hit |=> DATA_OE_O && DATA_O[2:0] == 3'h0 && !RDY_N_O)
        else $error("read image low bits not zero");
    AST_RESET: assert property ( // R18
        RESETN_I && $past(RESETN_I) == 1'b0 |-> !ENABLE_O && !MASTER_O && IRQ_N_O && RDY_N_O)
        else $error("reset values wrong");

    // ========================================
    // Checks: field storage
    AST_EN_FIRST: assert property ( // R01
        wr_ev && !st_r.en
        |=> !MASTER_O && !TRANSMIT_O && !st_r.ien && !st_r.ack_drive_value && $stable(st_r.tgl))
        else $error("control bits taken before enable");
    AST_DISABLE: assert property ( // R02
        wr_ev && !DATA_I[`CTRL_EN_BIT] |=> !ENABLE_O && !MASTER_O)
        else $error("controller not disabled");
    AST_IEN_STORE: assert property ( // R03
        seq_wr_fields |=> st_r.ien == $past(DATA_I[`CTRL_IEN_BIT]))
        else $error("interrupt enable not stored");
    AST_DIR_STORE: assert property ( // R08
        seq_wr_fields |=> TRANSMIT_O == $past(DATA_I[`CTRL_MTX_BIT]))
        else $error("direction bit not stored");
    AST_ACK_STORE: assert property ( // R09
        seq_wr_fields |=> st_r.ack_drive_value == $past(DATA_I[`CTRL_ACK_DRIVE_VALUE_BIT]))
        else $error("ack value not stored");
    AST_UNMAPPED: assert property ( // R17
        seq_rd_unmapped |=> DATA_OE_O && DATA_O == `UNMAPPED_DATA)
        else $error("unmapped read not zero");

    // ========================================
    // Checks: link requests
    AST_MASTER_HOLD: assert property ( // R05
        MASTER_O && !ARB_LOST_I && !wr_ev |=> MASTER_O)
        else $error("master select lost without cause");
    AST_START_CAUSE: assert property ( // R05
        $past(RESETN_I) && $changed(st_r.tgl[`REQ_START]) |-> MASTER_O && !$past(st_r.master_select))
        else $error("start requested without master rise");
    AST_STOP_CAUSE: assert property ( // R06
        $past(RESETN_I) && $changed(st_r.tgl[`REQ_STOP]) |-> $past(st_r.master_select) && !MASTER_O)
        else $error("stop requested without master clear");
    AST_RSTART: assert property ( // R11
        seq_wr_rstart |=> $changed(st_r.tgl[`REQ_RSTART]))
        else $error("repeated start not requested");
    AST_RSTART_IGNORED: assert property ( // R11
        (seq_wr_fields and (DATA_I[`CTRL_REPEAT_START_REQUEST_BIT] && !st_r.master_select))
        |=> $stable(st_r.tgl[`REQ_RSTART]))
        else $error("repeated start requested while slave");
    AST_RSTART_CAUSE: assert property ( // R11
        $past(RESETN_I) && $changed(st_r.tgl[`REQ_RSTART]) |-> $past(st_r.master_select))
        else $error("repeated start requested without master");
    AST_ARB_START: assert property ( // R14
        ARB_LOST_I |=> $stable(st_r.tgl[`REQ_START]) && !MASTER_O)
        else $error("start kept after lost arbitration");
    AST_BUSY_NO_START: assert property ( // R15
        (seq_wr_start and BUS_BUSY_I) |=> $stable(st_r.tgl[`REQ_START]))
        else $error("start requested while bus busy");

    // ========================================
    // Checks: interrupt and reset
    AST_IRQ_LEVEL: assert property ( // R16
        $past(RESETN_I) |-> IRQ_N_O == !($past(PENDING_I) && $past(st_r.ien)))
        else $error("interrupt output wrong level");
    AST_RESET_HOLD: assert property ( // R18
        disable iff (1'b0)
        !RESETN_I |=> !ENABLE_O && !MASTER_O && !TRANSMIT_O && IRQ_N_O && RDY_N_O && !DATA_OE_O && !ARB_LOST_O)
        else $error("reset not applied");
endmodule

// file: testbench/smbus_far_side.sv
// Far side of the two-wire bus: pull-ups, ack slot timing, START/STOP watch.
// Assumes open-drain enables from the controller, sampled on the link clock.
module smbus_far_side (
    input  wire logic link_clk_i,
    input  wire logic sda_oe_i,
    input  wire logic scl_oe_i,
    input  wire logic ack_cmd_i,
    output logic      ack_slot_o,
    output logic      sda_o,
    output logic      scl_o,
    output int        start_cnt_o,
    output int        stop_cnt_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic sda_q;
    logic scl_q;
    // ======
    // Pull-ups: a released line reads high
    assign sda_o = !sda_oe_i;
    assign scl_o = !scl_oe_i;
    initial begin
        ack_slot_o  = 1'b0;
        start_cnt_o = 0;
        stop_cnt_o  = 0;
        sda_q       = 1'b1;
        scl_q       = 1'b1;
    end
    // ======
    // Ack bit time on command
    always @(posedge link_clk_i) begin
        ack_slot_o <= ack_cmd_i;
    end
    // ======
    // Conditions: data edge while clock high
    always @(negedge link_clk_i) begin
        if (scl_q && scl_o && sda_q && !sda_o)
            start_cnt_o++;
        if (scl_q && scl_o && !sda_q && sda_o)
            stop_cnt_o++;
        sda_q = sda_o;
        scl_q = scl_o;
    end
endmodule

// file: testbench/tb_top.sv
// Self-checking bench of the control register and its link sequencer.
// Assumes the far-side model beside it; host bus driven on core clock edges.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk, link_clk, rst_n, bs_n, cs_n, rd_wrn, rd_n, we_n;
    logic       pending, arb_in, busy, ack_cmd, ack_slot, sda, scl;
    logic [7:0] addr, data_i, data_o;
    logic       data_oe, rdy_n, irq_n, arb_o, en_o, mst_o, tx_o;
    logic       sda_o, sda_oe, scl_o, scl_oe;
    int         start_cnt, stop_cnt, exp_start, exp_stop, arb_cnt, a0;
    int         err_count, total_checks;
    // ======
    // Clocks and instances
    initial begin
        clk = 1'b0;
        forever #12.5 clk = !clk;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #32 link_clk = !link_clk;
    end
    smbus_control i_smbus_control (.CORE_CLK_I(clk), .RESETN_I(rst_n), .LINK_CLK_I(link_clk),
        .ADDR_I(addr), .DATA_I(data_i), .DATA_O(data_o), .DATA_OE_O(data_oe), .BS_N_I(bs_n),
        .CS_N_I(cs_n), .RD_WRN_I(rd_wrn), .RD_N_I(rd_n), .WE_N_I(we_n), .RDY_N_O(rdy_n),
        .PENDING_I(pending), .ARB_LOST_I(arb_in), .BUS_BUSY_I(busy), .ACK_SLOT_I(ack_slot),
        .IRQ_N_O(irq_n), .ARB_LOST_O(arb_o), .ENABLE_O(en_o), .MASTER_O(mst_o),
        .TRANSMIT_O(tx_o), .SDA_O(sda_o), .SDA_OE_O(sda_oe), .SCL_O(scl_o), .SCL_OE_O(scl_oe));
    smbus_far_side i_smbus_far_side (.link_clk_i(link_clk), .sda_oe_i(sda_oe), .scl_oe_i(scl_oe),
        .ack_cmd_i(ack_cmd), .ack_slot_o(ack_slot), .sda_o(sda), .scl_o(scl),
        .start_cnt_o(start_cnt), .stop_cnt_o(stop_cnt));
    always @(posedge clk) begin
        if (arb_o === 1'b1)
            arb_cnt <= arb_cnt + 1;
    end
    // ======
    // Shared tasks
    task automatic stop_test();
        if (err_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic rw, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        @(posedge clk);
        bs_n   <= 1'b0;
        cs_n   <= 1'b0;
        addr   <= a;
        rd_wrn <= rw;
        @(posedge clk);
        bs_n   <= 1'b1;
        data_i <= d;
        if (rw)
            rd_n <= 1'b0;
        else
            we_n <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rdy_n !== 1'b0 && n < 10);
        if (n >= 10) begin
            err_count++;
            stop_test();
        end
        q = data_o;
        if (data_oe !== rw)
            chk({7'h00, data_oe}, {7'h00, rw});
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        we_n <= 1'b1;
    endtask
    task automatic wr(input logic [7:0] d);
        logic [7:0] q;
        bus(1'b0, 8'h90, d, q);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b1, a, 8'h00, q);
        chk(q, exp);
    endtask
    task automatic await_cnt(input bit stp);
        int exp;
        if (stp)
            exp_stop++;
        else
            exp_start++;
        exp = stp ? exp_stop : exp_start;
        for (int n = 0; n < 120; n++) begin
            @(posedge clk);
            if ((stp ? stop_cnt : start_cnt) == exp)
                break;
        end
        chk(8'(stp ? stop_cnt : start_cnt), 8'(exp));
    endtask
    // ======
    // Scenarios
    task automatic t_reset();
        rd_chk(8'h90, 8'h00);
        chk({4'h0, irq_n, en_o, mst_o, tx_o}, 8'h08);
    endtask
    task automatic t_gate();
        wr(8'h7c);
        rd_chk(8'h90, 8'h00);
        wr(8'hfc);
        rd_chk(8'h90, 8'h80);
        chk({6'h00, en_o, mst_o}, 8'h02);
    endtask
    task automatic t_fields();
        wr(8'h9f);
        rd_chk(8'h90, 8'h98);
        chk({7'h00, tx_o}, 8'h01);
        wr(8'h92);
        rd_chk(8'h92, 8'h00);
        wr(8'h88);
        chk({7'h00, tx_o}, 8'h00);
    endtask
    task automatic t_irq();
        pending <= 1'b1;
        wr(8'h80);
        repeat (2) @(posedge clk);
        chk({7'h00, irq_n}, 8'h01);
        wr(8'hc0);
        repeat (2) @(posedge clk);
        chk({7'h00, irq_n}, 8'h00);
        pending <= 1'b0;
        repeat (2) @(posedge clk);
        chk({7'h00, irq_n}, 8'h01);
        pending <= 1'b1;
        wr(8'h80);
        repeat (2) @(posedge clk);
        chk({7'h00, irq_n}, 8'h01);
        pending <= 1'b0;
    endtask
    task automatic t_master();
        repeat (8) @(posedge clk);
        wr(8'hb0);
        await_cnt(1'b0);
        chk({7'h00, mst_o}, 8'h01);
        wr(8'hb4);
        await_cnt(1'b0);
        rd_chk(8'h90, 8'hb0);
        wr(8'h90);
        await_cnt(1'b1);
        chk({7'h00, mst_o}, 8'h00);
    endtask
    task automatic t_arb();
        busy <= 1'b1;
        a0 = arb_cnt;
        wr(8'ha0);
        repeat (3) @(posedge clk);
        rd_chk(8'h90, 8'h80);
        chk(8'(arb_cnt - a0), 8'h01);
        wr(8'h84);
        repeat (3) @(posedge clk);
        chk(8'(arb_cnt - a0), 8'h02);
        busy <= 1'b0;
        wr(8'ha0);
        await_cnt(1'b0);
        arb_in <= 1'b1;
        @(posedge clk);
        arb_in <= 1'b0;
        repeat (60) @(posedge clk);
        chk({7'h00, mst_o}, 8'h00);
        chk(8'(arb_cnt - a0), 8'h03);
        chk(8'(stop_cnt), 8'(exp_stop));
    endtask
    task automatic t_ack();
        logic [7:0] cfg [4] = '{8'h80, 8'h88, 8'h90, 8'h00};
        logic [7:0] lvl [4] = '{8'h00, 8'h01, 8'h01, 8'h01};
        for (int i = 0; i < 4; i++) begin
            wr(cfg[i]);
            repeat (12) @(posedge clk);
            ack_cmd <= 1'b1;
            repeat (12) @(posedge clk);
            chk({7'h00, sda}, lvl[i]);
            chk({6'h00, sda_o, scl_o}, 8'h00);
            ack_cmd <= 1'b0;
            repeat (12) @(posedge clk);
        end
    endtask
    // ======
    // Main sequence
    initial begin
        {rst_n, rd_wrn, pending, arb_in, busy, ack_cmd} = '0;
        {bs_n, cs_n, rd_n, we_n} = 4'hf;
        {addr, data_i} = '0;
        {err_count, total_checks, arb_cnt} = '0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        exp_start = start_cnt;
        exp_stop  = stop_cnt;
        t_reset();
        t_gate();
        t_fields();
        t_irq();
        t_master();
        t_arb();
        t_ack();
        stop_test();
    end
endmodule
